// ===== i2cms_params.svh
// offsets, field positions, reset values and timing counts of the i2c master start/baud block
`ifndef I2CMS_PARAMS_SVH
`define I2CMS_PARAMS_SVH
// register byte offsets
`define I2CMS_OFF_CTRL1 8'h00
`define I2CMS_OFF_CTRL2 8'h04
`define I2CMS_OFF_STATUS 8'h08
`define I2CMS_OFF_BAUD 8'h0C
`define I2CMS_OFF_BUF 8'h10
`define I2CMS_OFF_FLAGS 8'h14
// serial_ctrl2 fields
`define I2CMS_C2_START 0
`define I2CMS_C2_RSTART 1
`define I2CMS_C2_STOP 2
`define I2CMS_C2_RXEN 3
`define I2CMS_C2_ACKDATA 5
`define I2CMS_C2_ACKSTAT 6
// serial_status fields
`define I2CMS_ST_BUFFULL 0
`define I2CMS_ST_START 3
`define I2CMS_ST_STOP 4
// flag register fields, write one to clear
`define I2CMS_FL_IRQ 0
`define I2CMS_FL_BCOL 1
`define I2CMS_FL_WRITE_COLLISION_FLAG 2
// reset values
`define I2CMS_RST_BAUD 7'h64
`define I2CMS_RST_BYTE 8'h00
// timing: instruction cycle and reference clock in ns
`define I2CMS_INSTR_NS 100
`define I2CMS_CLK_NS 10
// reference cycles per baud generator decrement (two decrements per instruction cycle)
`define I2CMS_PHASE_CYC ((`I2CMS_INSTR_NS / 2) / `I2CMS_CLK_NS)
// last bit index of a byte plus acknowledge
`define I2CMS_ACK_BIT 4'h8
`endif

// ===== i2cms_pkg.sv
// types shared by the i2c master start/baud block
package i2cms_pkg;
  // sequencer states, one-hot
  typedef enum logic [11:0] {
    IDLE = 12'h001,
    ST_WAIT = 12'h002,
    ST_HOLD = 12'h004,
    RS_LOW = 12'h008,
    RS_SDAHI = 12'h010,
    RS_SCLREL = 12'h020,
    RS_SDALO = 12'h040,
    SP_SDALO = 12'h080,
    SP_SCLHI = 12'h100,
    SP_SDAHI = 12'h200,
    BY_LOW = 12'h400,
    BY_HIGH = 12'h800
  } i2cms_state_t;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } i2cms_reg_req_t;
endpackage : i2cms_pkg

// ===== i2cms_master.sv
// i2c master bus-condition sequencer with baud generator, clock arbitration and collision checks
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "i2cms_params.svh"
// Function
// [R1] master makes all clock pulses, start, stop
// [R2] transfer ends by stop or repeated start
// [R3] transmitter first byte: address, direction zero
// [R4] receiver first byte: address, direction one; acks
// [R5] bytes of eight bits plus acknowledge
// [R6] baud reload from low seven bits; the first repeated start load (RS_LOW) takes only the low six
// [R7] buffer write starts generator; counts to zero
// [R8] two decrements per instruction cycle, auto reload
// [R9] one clock period is two rollovers
// [R10] after operation clock stops, line kept
// [R11] released clock pauses generator until high
// [R12] start: both high at timeout, drive data low
// [R13] start hold one period, then clear enable
// [R14] start collision on low lines, abort idle
// [R15] buffer write during sequence: discard, flag
// [R16] low control bits locked while event pending
// [R17] repeated start only from idle, clock low
// [R18] repeated start release, hold high, drive low
// [R19] start bit early, irq after timeout
// [R20] repeated start ignored while busy
// [R21] repeated start collisions flagged
// [R22] ack captured to bit six, irq after ninth
// [R23] stop enable makes stop, irq after
// [R24] start/stop status cleared by reset, disable
// [R25] open-drain lines, sampled level is truth
// [R26] one sequencer, one request at a time
module i2cms_master (
  // clock, reset, clock enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire i2cms_pkg::i2cms_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // serial clock line
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // serial data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);

  // sequencer state and baud generator
  i2cms_pkg::i2cms_state_t state_q;
  logic [6:0] cnt_q; // baud generator count
  logic armed_q; // phase has seen its start condition and loaded
  logic [3:0] bit_q; // bit index inside a byte, 8 is acknowledge
  logic [7:0] shift_q; // shift register
  logic rx_q; // byte in progress is a receive
  logic ack_q; // last acknowledge from slave
  logic scl_oe_n_q;
  logic sda_oe_n_q;
  // one-cycle events from the sequencer
  logic ev_start_q;
  logic ev_stop_q;
  logic ev_irq_q;
  logic ev_bcol_q;
  logic ev_txdone_q;
  logic ev_rxdone_q;
  logic [3:0] ev_clr_q; // enable bits the hardware clears
  // software registers
  logic en_q; // module enable
  logic [5:0] ctrl_q; // serial_ctrl2 writable bits
  logic [6:0] baud_q; // addr_baud_reg
  logic [7:0] buf_q; // xfer_buffer
  logic bf_q;
  logic s_q;
  logic p_q;
  logic irq_q;
  logic bcol_q;
  logic write_collision_flag_q;
  logic [7:0] rdata_q;
  // phase divider
  logic [2:0] ph_cnt_q;
  logic phase_four_q; // which phase the next decrement falls on
  logic tick;
  logic to;
  // synchronised lines
  logic [1:0] pin_in;
  logic [1:0] pin_q;
  logic scl_q;
  logic sda_q;
  // decode
  logic busy;
  logic wr_buf;
  logic wr_ctrl2;
  logic buf_go;
  logic [3:0] req;

  // open-drain: the output value is always low, only the enable moves
  assign scl_o = 1'b0; // [R25]
  assign sda_o = 1'b0; // [R25]
  assign scl_oe_n = scl_oe_n_q;
  assign sda_oe_n = sda_oe_n_q;
  assign reg_rdata = rdata_q;

  // three-stage synchroniser per line; the level moves once stages two and three agree
  assign pin_in = {sda_i, scl_i};
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        s3_q <= 1'b1;
        pin_q[gi] <= 1'b1;
      end
      else if (ce)
      begin
        s1_q <= pin_in[gi];
        s2_q <= s1_q;
        s3_q <= s2_q;
        // filters a one-cycle glitch at the cost of one more cycle of latency
        if (s2_q == s3_q)
        begin
          pin_q[gi] <= s3_q;
        end
      end
    end
  end
  // the sampled wire, not our own drive, is the line state
  assign scl_q = pin_q[0]; // [R25]
  assign sda_q = pin_q[1]; // [R25]

  // phase divider: one decrement every half instruction cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ph_cnt_q <= 3'h0;
      phase_four_q <= 1'b0;
    end
    else if (ce)
    begin
      if (tick)
      begin
        ph_cnt_q <= 3'h0;
        phase_four_q <= ~phase_four_q; // [R8]
      end
      else
      begin
        ph_cnt_q <= ph_cnt_q + 3'h1;
      end
    end
  end
  assign tick = (ph_cnt_q == 3'(`I2CMS_PHASE_CYC - 1)); // [R8]
  // timeout when the count reaches zero on this decrement
  assign to = tick && (cnt_q <= 7'h01); // [R7]

  // request decode
  assign busy = (state_q != i2cms_pkg::IDLE) || (ctrl_q[3:0] != 4'h0);
  assign wr_buf = reg_req.wr && (reg_req.addr == `I2CMS_OFF_BUF);
  assign wr_ctrl2 = reg_req.wr && (reg_req.addr == `I2CMS_OFF_CTRL2);
  assign buf_go = wr_buf && !busy; // [R26]
  // a finished request still sits in ctrl_q for one cycle; mask it so idle does not run it again
  assign req = ctrl_q[3:0] & ~ev_clr_q; // [R26]

  // next data line drive for a bit; one means released
  function automatic logic sda_bit(input logic rx, input logic [3:0] b, input logic [7:0] sh, input logic ackd);
    logic v;
    v = 1'b1;
    if (b == `I2CMS_ACK_BIT)
    begin
      v = rx ? ackd : 1'b1; // [R4] [R5]
    end
    else
    begin
      v = rx ? 1'b1 : sh[7]; // [R3] [R5]
    end
    return v;
  endfunction : sda_bit

  // sequencer with baud generator: start, repeated start, stop, byte
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= i2cms_pkg::IDLE;
      cnt_q <= 7'h00;
      armed_q <= 1'b0;
      bit_q <= 4'h0;
      shift_q <= `I2CMS_RST_BYTE;
      rx_q <= 1'b0;
      ack_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      ev_start_q <= 1'b0;
      ev_stop_q <= 1'b0;
      ev_irq_q <= 1'b0;
      ev_bcol_q <= 1'b0;
      ev_txdone_q <= 1'b0;
      ev_rxdone_q <= 1'b0;
      ev_clr_q <= 4'h0;
    end
    else if (ce)
    begin
      ev_start_q <= 1'b0;
      ev_stop_q <= 1'b0;
      ev_irq_q <= 1'b0;
      ev_bcol_q <= 1'b0;
      ev_txdone_q <= 1'b0;
      ev_rxdone_q <= 1'b0;
      ev_clr_q <= 4'h0;
      // free decrement toward zero, then hold
      if (tick && cnt_q != 7'h00)
      begin
        cnt_q <= cnt_q - 7'h01; // [R7] [R8]
      end
      if (!en_q)
      begin
        // disabled: release both lines and forget the sequence
        state_q <= i2cms_pkg::IDLE;
        scl_oe_n_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
        armed_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          i2cms_pkg::IDLE:
          begin
            armed_q <= 1'b0;
            if (req[`I2CMS_C2_START])
            begin
              if (!sda_q && !scl_q)
              begin
                ev_bcol_q <= 1'b1; // [R14]
                ev_clr_q <= 4'h1;
              end
              else if (sda_q && scl_q)
              begin
                cnt_q <= baud_q; // [R6] [R12]
                state_q <= i2cms_pkg::ST_WAIT;
              end
            end
            else if (req[`I2CMS_C2_RSTART])
            begin
              scl_oe_n_q <= 1'b0; // [R17]
              state_q <= i2cms_pkg::RS_LOW;
            end
            else if (req[`I2CMS_C2_STOP])
            begin
              sda_oe_n_q <= 1'b0; // [R23]
              state_q <= i2cms_pkg::SP_SDALO;
            end
            else if (req[`I2CMS_C2_RXEN] || buf_go)
            begin
              // a byte begins with the clock pulled low for one rollover
              rx_q <= req[`I2CMS_C2_RXEN];
              shift_q <= reg_req.wdata; // [R7]
              bit_q <= 4'h0;
              scl_oe_n_q <= 1'b0; // [R1]
              cnt_q <= baud_q;
              state_q <= i2cms_pkg::BY_LOW;
            end
          end
          i2cms_pkg::ST_WAIT:
          begin
            // clock falling before our data edge means someone else owns the bus
            if (!scl_q || (to && !sda_q))
            begin
              ev_bcol_q <= 1'b1; // [R14]
              ev_clr_q <= 4'h1;
              sda_oe_n_q <= 1'b1;
              state_q <= i2cms_pkg::IDLE;
            end
            else if (to)
            begin
              sda_oe_n_q <= 1'b0; // [R12]
              ev_start_q <= 1'b1;
              cnt_q <= baud_q; // [R13]
              state_q <= i2cms_pkg::ST_HOLD;
            end
          end
          i2cms_pkg::ST_HOLD:
          begin
            if (to)
            begin
              ev_clr_q <= 4'h1; // [R13]
              ev_irq_q <= 1'b1;
              state_q <= i2cms_pkg::IDLE;
            end
          end
          i2cms_pkg::RS_LOW:
          begin
            if (!scl_q)
            begin
              cnt_q <= {1'b0, baud_q[5:0]}; // [R17]
              sda_oe_n_q <= 1'b1;
              state_q <= i2cms_pkg::RS_SDAHI;
            end
          end
          i2cms_pkg::RS_SDAHI:
          begin
            if (to)
            begin
              if (sda_q)
              begin
                scl_oe_n_q <= 1'b1; // [R18]
                armed_q <= 1'b0;
                state_q <= i2cms_pkg::RS_SCLREL;
              end
              else
              begin
                ev_bcol_q <= 1'b1; // [R21]
                ev_clr_q <= 4'h2;
                scl_oe_n_q <= 1'b1;
                state_q <= i2cms_pkg::IDLE;
              end
            end
          end
          i2cms_pkg::RS_SCLREL:
          begin
            if (!armed_q)
            begin
              if (scl_q && !sda_q)
              begin
                ev_bcol_q <= 1'b1; // [R21]
                ev_clr_q <= 4'h2;
                state_q <= i2cms_pkg::IDLE;
              end
              else if (scl_q)
              begin
                cnt_q <= baud_q; // [R18] [R11]
                armed_q <= 1'b1;
              end
            end
            else if (!scl_q)
            begin
              ev_bcol_q <= 1'b1; // [R21]
              ev_clr_q <= 4'h2;
              state_q <= i2cms_pkg::IDLE;
            end
            else if (to)
            begin
              sda_oe_n_q <= 1'b0; // [R18]
              ev_start_q <= 1'b1; // [R19]
              cnt_q <= baud_q;
              state_q <= i2cms_pkg::RS_SDALO;
            end
          end
          i2cms_pkg::RS_SDALO:
          begin
            if (to)
            begin
              ev_clr_q <= 4'h2; // [R18] [R2]
              ev_irq_q <= 1'b1; // [R19]
              state_q <= i2cms_pkg::IDLE;
            end
          end
          i2cms_pkg::SP_SDALO:
          begin
            if (!armed_q && !sda_q)
            begin
              cnt_q <= baud_q;
              armed_q <= 1'b1;
            end
            else if (armed_q && to)
            begin
              scl_oe_n_q <= 1'b1; // [R23]
              armed_q <= 1'b0;
              state_q <= i2cms_pkg::SP_SCLHI;
            end
          end
          i2cms_pkg::SP_SCLHI:
          begin
            if (!armed_q && scl_q)
            begin
              cnt_q <= baud_q; // [R11]
              armed_q <= 1'b1;
            end
            else if (armed_q && to)
            begin
              sda_oe_n_q <= 1'b1; // [R23]
              armed_q <= 1'b0;
              state_q <= i2cms_pkg::SP_SDAHI;
            end
          end
          i2cms_pkg::SP_SDAHI:
          begin
            if (!armed_q && sda_q && scl_q)
            begin
              ev_stop_q <= 1'b1;
              cnt_q <= baud_q;
              armed_q <= 1'b1;
            end
            else if (armed_q && to)
            begin
              ev_clr_q <= 4'h4; // [R23] [R2]
              ev_irq_q <= 1'b1;
              state_q <= i2cms_pkg::IDLE;
            end
          end
          i2cms_pkg::BY_LOW:
          begin
            // data changes one cycle after the clock is low, never while it is high
            if (!armed_q)
            begin
              sda_oe_n_q <= sda_bit(rx_q, bit_q, shift_q, ctrl_q[`I2CMS_C2_ACKDATA]); // [R5]
              armed_q <= 1'b1;
            end
            else if (to)
            begin
              scl_oe_n_q <= 1'b1; // [R9]
              armed_q <= 1'b0;
              state_q <= i2cms_pkg::BY_HIGH;
            end
          end
          i2cms_pkg::BY_HIGH:
          begin
            if (!armed_q)
            begin
              // stretched clock: count only once the line really reads high
              if (scl_q)
              begin
                cnt_q <= baud_q; // [R11]
                armed_q <= 1'b1;
              end
            end
            else if (to)
            begin
              scl_oe_n_q <= 1'b0; // [R9]
              armed_q <= 1'b0;
              if (bit_q == `I2CMS_ACK_BIT)
              begin
                // byte over: generator stops, clock left low
                if (!rx_q)
                begin
                  ack_q <= sda_q; // [R22]
                end
                ev_txdone_q <= !rx_q;
                ev_rxdone_q <= rx_q;
                ev_clr_q <= {rx_q, 3'h0};
                ev_irq_q <= 1'b1; // [R22]
                state_q <= i2cms_pkg::IDLE; // [R10]
              end
              else
              begin
                shift_q <= {shift_q[6:0], sda_q}; // [R5]
                bit_q <= bit_q + 4'h1;
                cnt_q <= baud_q;
                state_q <= i2cms_pkg::BY_LOW;
              end
            end
          end
          default:
          begin
            state_q <= i2cms_pkg::IDLE;
          end
        endcase
      end
    end
  end

  // control registers: enable, serial_ctrl2, baud reload
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      en_q <= 1'b0;
      ctrl_q <= 6'h00;
      baud_q <= `I2CMS_RST_BAUD;
    end
    else if (ce)
    begin
      if (reg_req.wr && reg_req.addr == `I2CMS_OFF_CTRL1)
      begin
        en_q <= reg_req.wdata[0];
      end
      if (reg_req.wr && reg_req.addr == `I2CMS_OFF_BAUD)
      begin
        baud_q <= reg_req.wdata[6:0]; // [R6]
      end
      if (!en_q)
      begin
        ctrl_q[3:0] <= 4'h0;
      end
      else if (wr_ctrl2 && !busy)
      begin
        // one request at a time: a write asking for several keeps the lowest
        ctrl_q[3:0] <= reg_req.wdata[3:0] & (~reg_req.wdata[3:0] + 4'h1); // [R26] [R20]
      end
      else
      begin
        // while busy the low bits are locked; events cannot be queued
        ctrl_q[3:0] <= ctrl_q[3:0] & ~ev_clr_q; // [R16] [R13]
      end
      if (wr_ctrl2)
      begin
        ctrl_q[5:4] <= {reg_req.wdata[5], 1'b0};
      end
    end
  end

  // transfer buffer and buffer-full flag
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      buf_q <= `I2CMS_RST_BYTE;
      bf_q <= 1'b0;
    end
    else if (ce)
    begin
      if (ev_rxdone_q)
      begin
        buf_q <= shift_q; // [R4]
        bf_q <= 1'b1;
      end
      else if (buf_go && en_q)
      begin
        buf_q <= reg_req.wdata; // [R7]
        bf_q <= 1'b1;
      end
      else if (ev_txdone_q || (reg_req.rd && reg_req.addr == `I2CMS_OFF_BUF))
      begin
        bf_q <= 1'b0;
      end
    end
  end

  // sticky flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      irq_q <= 1'b0;
      bcol_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
    end
    else if (ce)
    begin
      if (reg_req.wr && reg_req.addr == `I2CMS_OFF_FLAGS)
      begin
        irq_q <= ev_irq_q | (irq_q & ~reg_req.wdata[`I2CMS_FL_IRQ]);
        bcol_q <= ev_bcol_q | (bcol_q & ~reg_req.wdata[`I2CMS_FL_BCOL]);
        write_collision_flag_q <= (wr_buf && busy) | (write_collision_flag_q & ~reg_req.wdata[`I2CMS_FL_WRITE_COLLISION_FLAG]);
      end
      else
      begin
        irq_q <= irq_q | ev_irq_q; // [R22]
        bcol_q <= bcol_q | ev_bcol_q; // [R14]
        write_collision_flag_q <= write_collision_flag_q | (wr_buf && busy); // [R15]
      end
    end
  end

  // bus-condition status: start and stop exclude each other
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q <= 1'b0;
      p_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!en_q)
      begin
        s_q <= 1'b0; // [R24]
        p_q <= 1'b0; // [R24]
      end
      else if (ev_start_q)
      begin
        s_q <= 1'b1; // [R12] [R19]
        p_q <= 1'b0;
      end
      else if (ev_stop_q)
      begin
        s_q <= 1'b0;
        p_q <= 1'b1;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      rdata_q <= 8'h00;
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          `I2CMS_OFF_CTRL1: rdata_q <= {7'h00, en_q};
          `I2CMS_OFF_CTRL2: rdata_q <= {1'b0, ack_q, ctrl_q}; // [R22]
          `I2CMS_OFF_STATUS: rdata_q <= {3'h0, p_q, s_q, 2'h0, bf_q};
          `I2CMS_OFF_BAUD: rdata_q <= {1'b0, baud_q};
          `I2CMS_OFF_BUF: rdata_q <= buf_q;
          `I2CMS_OFF_FLAGS: rdata_q <= {5'h00, write_collision_flag_q, bcol_q, irq_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // checks
  property p_write_collision_flag;
    @(posedge ref_clk) disable iff (reset || !ce)
    (wr_buf && busy && en_q) |=> (write_collision_flag_q && buf_q == $past(buf_q));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("buffer write during sequence not refused"); // [R15]
  property p_lock;
    @(posedge ref_clk) disable iff (reset || !ce)
    (wr_ctrl2 && busy && en_q && ev_clr_q == 4'h0) |=> (ctrl_q[3:0] == $past(ctrl_q[3:0]));
  endproperty
  a_lock: assert property (p_lock) else $error("control bits changed while locked"); // [R16]
  property p_start_edge;
    @(posedge ref_clk) disable iff (reset || !ce || !en_q)
    (state_q == i2cms_pkg::ST_WAIT && to && scl_q && sda_q) |=> (!sda_oe_n && state_q == i2cms_pkg::ST_HOLD)
      ##1 s_q;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start edge or start status missing"); // [R12]
  property p_start_done;
    @(posedge ref_clk) disable iff (reset || !ce || !en_q)
    (state_q == i2cms_pkg::ST_HOLD && to) |=> ##1 (!ctrl_q[0] && irq_q && !sda_oe_n);
  endproperty
  a_start_done: assert property (p_start_done) else $error("start did not complete"); // [R13]
  property p_start_col;
    @(posedge ref_clk) disable iff (reset || !ce || !en_q)
    (state_q == i2cms_pkg::IDLE && req[0] && !sda_q && !scl_q) |=> ##1 (bcol_q && state_q == i2cms_pkg::IDLE);
  endproperty
  a_start_col: assert property (p_start_col) else $error("start collision not flagged"); // [R14]
  property p_stretch;
    @(posedge ref_clk) disable iff (reset || !ce || !en_q)
    (state_q == i2cms_pkg::BY_HIGH && !armed_q && !scl_q && !tick) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_stretch: assert property (p_stretch) else $error("generator ran during stretched clock"); // [R11]
  property p_tick;
    @(posedge ref_clk) disable iff (reset || !ce)
    tick |=> !tick [*4] ##1 tick;
  endproperty
  a_tick: assert property (p_tick) else $error("decrement spacing wrong"); // [R8]
  property p_rs_idle;
    @(posedge ref_clk) disable iff (reset || !ce || !en_q)
    (state_q == i2cms_pkg::RS_LOW && !scl_q) |=> (cnt_q[6] == 1'b0 && sda_oe_n);
  endproperty
  a_rs_idle: assert property (p_rs_idle) else $error("repeated start load wrong"); // [R17]
  property p_byte_irq;
    @(posedge ref_clk) disable iff (reset || !ce || !en_q)
    (state_q == i2cms_pkg::BY_HIGH && armed_q && to && bit_q == 4'h8) |=> ##1 (irq_q && !scl_oe_n);
  endproperty
  a_byte_irq: assert property (p_byte_irq) else $error("byte end not flagged"); // [R22]
  c_start: cover property (@(posedge ref_clk) disable iff (reset) ev_start_q && state_q == i2cms_pkg::ST_HOLD);
  c_rstart: cover property (@(posedge ref_clk) disable iff (reset) state_q == i2cms_pkg::RS_SDALO && to);
  c_stop: cover property (@(posedge ref_clk) disable iff (reset) ev_stop_q);
  c_byte: cover property (@(posedge ref_clk) disable iff (reset) ev_txdone_q);

endmodule : i2cms_master

// ===== i2cms_slave_model.sv
// behavioural i2c slave: acks only the first byte after a start, keeps that byte
`timescale 1ns/10ps
module i2cms_slave_model (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  // high pulls data low; first byte in after the latest start
  output logic sda_pull,
  output logic [7:0] rx_byte
);
  int nfall = 0; // clock falls since last start
  initial sda_pull = 1'b0;
  initial rx_byte = 8'h00;
  // a start restarts the bit count
  always @(negedge sda)
    if (scl)
      nfall = 0;
  // bits are taken while the clock is high
  always @(posedge scl)
    if (nfall >= 1 && nfall <= 8)
      rx_byte = {rx_byte[6:0], sda};
  // ack in bit nine, freed at the next fall so the master gets the wire back
  always @(negedge scl)
  begin
    nfall = nfall + 1;
    sda_pull = (nfall == 9);
  end
endmodule : i2cms_slave_model

// ===== i2cms_master_tb.sv
// self-checking bench for the i2c master start/baud block
`timescale 1ns/10ps
module i2cms_master_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1; // clock enable, dropped once to prove the freeze
  i2cms_pkg::i2cms_reg_req_t req = '0;
  logic [7:0] rdata, v, rx;
  logic scl_oe_n, sda_oe_n, sda_pull;
  logic bus_low = 1'b0; // both wires low, to provoke a collision
  int n_errors = 0;
  int check_count = 0;
  // open-drain wires with pull-ups
  wire scl_w = scl_oe_n & ~bus_low;
  wire sda_w = sda_oe_n & ~sda_pull & ~bus_low;
  always #5 ref_clk = ~ref_clk;
  i2cms_master i2cms_master_i (.ref_clk(ref_clk), .reset(reset), .ce(ce), .reg_req(req), .reg_rdata(rdata),
    .scl_i(scl_w), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(), .sda_oe_n(sda_oe_n));
  i2cms_slave_model i2cms_slave_model_i (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .rx_byte(rx));
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : reg_wr
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_rd(a);
    chk(name, v & m, e);
  endtask : rd_chk
  // poll the flags, bounded
  task automatic wait_flag(input logic [7:0] m);
    int i;
    v = 8'h00;
    for (i = 0; i < 1000 && (v & m) !== m; i++)
      reg_rd(8'h14);
    if ((v & m) !== m)
    begin
      n_errors++;
      complete_run();
    end
  endtask : wait_flag
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk("baud", 8'h0C, 8'h7F, 8'h64);
    rd_chk("status", 8'h08, 8'hFF, 8'h00);
    reg_wr(8'h00, 8'h01);
    reg_wr(8'h0C, 8'h84); // top bit lies outside the reload
    reg_wr(8'h04, 8'h01);
    reg_wr(8'h10, 8'h3C);
    reg_wr(8'h04, 8'h04);
    rd_chk("ctrl2 locked", 8'h04, 8'h1F, 8'h01);
    rd_chk("write_collision_flag", 8'h14, 8'h04, 8'h04);
    wait_flag(8'h01);
    rd_chk("start seen", 8'h08, 8'h08, 8'h08);
    rd_chk("start done", 8'h04, 8'h01, 8'h00);
    chk("start lines", {6'h00, scl_w, sda_w}, 8'h02);
    reg_wr(8'h14, 8'h07);
    reg_wr(8'h10, 8'hA4);
    wait_flag(8'h01);
    chk("slave rx", rx, 8'hA4);
    rd_chk("ack status", 8'h04, 8'h40, 8'h00);
    chk("clock held", {7'h00, scl_oe_n}, 8'h00);
    // receive: the slave leaves data released, so the byte reads all ones
    reg_wr(8'h14, 8'h07);
    reg_wr(8'h04, 8'h08);
    wait_flag(8'h01);
    rd_chk("rx full", 8'h08, 8'h01, 8'h01);
    rd_chk("rx byte", 8'h10, 8'hFF, 8'hFF);
    rd_chk("rx done", 8'h04, 8'h08, 8'h00);
    // disabling drops start status, so the repeated start below sets it afresh
    reg_wr(8'h00, 8'h00);
    rd_chk("status off", 8'h08, 8'h18, 8'h00);
    reg_wr(8'h00, 8'h01);
    reg_wr(8'h14, 8'h07);
    reg_wr(8'h04, 8'h02);
    wait_flag(8'h01);
    rd_chk("rstart seen", 8'h08, 8'h08, 8'h08);
    rd_chk("rstart done", 8'h04, 8'h02, 8'h00);
    chk("rstart lines", {6'h00, scl_w, sda_w}, 8'h02);
    reg_wr(8'h14, 8'h07);
    reg_wr(8'h04, 8'h04);
    wait_flag(8'h01);
    rd_chk("stop seen", 8'h08, 8'h10, 8'h10);
    chk("idle lines", {6'h00, scl_w, sda_w}, 8'h03);
    rd_chk("unmapped", 8'h20, 8'hFF, 8'h00);
    // a write while the clock enable is low must be lost
    @(posedge ref_clk);
    ce <= 1'b0;
    reg_wr(8'h0C, 8'h10);
    ce <= 1'b1;
    rd_chk("ce freeze", 8'h0C, 8'h7F, 8'h04);
    reg_wr(8'h14, 8'h07);
    bus_low <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reg_wr(8'h04, 8'h01);
    wait_flag(8'h02);
    rd_chk("start aborted", 8'h04, 8'h01, 8'h00);
    bus_low <= 1'b0;
    complete_run();
  end
endmodule : i2cms_master_tb
